//--- design/jct_defines.vh
`ifndef JCT_DEFINES_VH
`define JCT_DEFINES_VH

// ****************************************
// TAP states
// ****************************************
`define JCT_ST_RESET     4'h0
`define JCT_ST_IDLE      4'h1
`define JCT_ST_SEL_DR    4'h2
`define JCT_ST_CAP_DR    4'h3
`define JCT_ST_SHIFT_DR  4'h4
`define JCT_ST_EXIT1_DR  4'h5
`define JCT_ST_PAUSE_DR  4'h6
`define JCT_ST_EXIT2_DR  4'h7
`define JCT_ST_UPD_DR    4'h8
`define JCT_ST_SEL_IR    4'h9
`define JCT_ST_CAP_IR    4'ha
`define JCT_ST_SHIFT_IR  4'hb
`define JCT_ST_EXIT1_IR  4'hc
`define JCT_ST_PAUSE_IR  4'hd
`define JCT_ST_EXIT2_IR  4'he
`define JCT_ST_UPD_IR    4'hf

// ****************************************
// Instruction codes
// ****************************************
`define JCT_IR_W         5
`define JCT_OP_EXTEST    5'h00
`define JCT_OP_SEL_CFG   5'h01
`define JCT_OP_ERASE     5'h02
`define JCT_OP_VERIFY    5'h03
`define JCT_OP_PROGRAM   5'h04
`define JCT_OP_IDCODE    5'h0d
`define JCT_OP_CALIB     5'h10
`define JCT_OP_SAMPLE    5'h1e
`define JCT_OP_BYPASS    5'h1f

// ****************************************
// Register sizes and values
// ****************************************
`define JCT_ID_W         32
`define JCT_CFG_W        109
`define JCT_ID_VALUE     32'h0a5a5001
`define JCT_LOCK_POS     108
`define JCT_SYNC_RESET   2'h0

`endif

//--- design/jct_tap_fsm.v
`timescale 1ns/10ps
// ****************************************
// Sixteen-state TAP controller
// ****************************************
module jct_tap_fsm (
    clk_sys,
    rst_sync_b,
    ce,
    tck_rise,
    tms,
    state_reg
);
`include "jct_defines.vh"
    input  wire       clk_sys;
    input  wire       rst_sync_b;
    input  wire       ce;
    input  wire       tck_rise;
    input  wire       tms;
    output reg  [3:0] state_reg;

    reg [3:0] state_next;

    always @* begin
        case (state_reg)
            `JCT_ST_RESET:    state_next = tms ? `JCT_ST_RESET : `JCT_ST_IDLE;
            `JCT_ST_IDLE:     state_next = tms ? `JCT_ST_SEL_DR : `JCT_ST_IDLE;
            `JCT_ST_SEL_DR:   state_next = tms ? `JCT_ST_SEL_IR : `JCT_ST_CAP_DR;
            `JCT_ST_CAP_DR:   state_next = tms ? `JCT_ST_EXIT1_DR : `JCT_ST_SHIFT_DR;
            `JCT_ST_SHIFT_DR: state_next = tms ? `JCT_ST_EXIT1_DR : `JCT_ST_SHIFT_DR;
            `JCT_ST_EXIT1_DR: state_next = tms ? `JCT_ST_UPD_DR : `JCT_ST_PAUSE_DR;
            `JCT_ST_PAUSE_DR: state_next = tms ? `JCT_ST_EXIT2_DR : `JCT_ST_PAUSE_DR;
            `JCT_ST_EXIT2_DR: state_next = tms ? `JCT_ST_UPD_DR : `JCT_ST_SHIFT_DR;
            `JCT_ST_UPD_DR:   state_next = tms ? `JCT_ST_SEL_DR : `JCT_ST_IDLE;
            `JCT_ST_SEL_IR:   state_next = tms ? `JCT_ST_RESET : `JCT_ST_CAP_IR;
            `JCT_ST_CAP_IR:   state_next = tms ? `JCT_ST_EXIT1_IR : `JCT_ST_SHIFT_IR;
            `JCT_ST_SHIFT_IR: state_next = tms ? `JCT_ST_EXIT1_IR : `JCT_ST_SHIFT_IR;
            `JCT_ST_EXIT1_IR: state_next = tms ? `JCT_ST_UPD_IR : `JCT_ST_PAUSE_IR;
            `JCT_ST_PAUSE_IR: state_next = tms ? `JCT_ST_EXIT2_IR : `JCT_ST_PAUSE_IR;
            `JCT_ST_EXIT2_IR: state_next = tms ? `JCT_ST_UPD_IR : `JCT_ST_SHIFT_IR;
            `JCT_ST_UPD_IR:   state_next = tms ? `JCT_ST_SEL_DR : `JCT_ST_IDLE;
            default:          state_next = `JCT_ST_RESET;
        endcase
    end

    always @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_reg <= `JCT_ST_RESET;
        end else if (ce && tck_rise) begin
            state_reg <= state_next;
        end
    end
endmodule // jct_tap_fsm

//--- design/jct_config_tap.v
`timescale 1ns/10ps
`include "jct_defines.vh"
// Operation
// - Lock bit set blocks config readout until erase and reprogram.
// - No boundary cells; behaves as a normal chain member.
// - One-bit bypass register gives one-stage path TDI to TDO.
// - Boundary-scan instructions select bypass register instead.
// - Identification and configuration data registers beside bypass.
// - Sixteen-state controller advances on TCK rising, steered by TMS.
// - TDI and TMS sampled on TCK rise, TDO changes on fall.
// - Only Test-Logic-Reset holds with TMS high; five clocks reset.
// - TRST low forces Test-Logic-Reset immediately; also power-on state.
// - Reset exits to Run-Test/Idle, which idles until a scan.
// - Capture-DR loads the selected data register into the path.
// - Capture-IR loads identification code; identification current after reset.
// - Capture to Shift or Exit1; Pause through Exit2 or Update.
// - Program, erase, verify start on next Run-Test/Idle entry; here on the first TCK rise in Run-Test/Idle.
// - Instruction register is five bits long.
// - Bypass instruction selects bypass, normal operation untouched.
// - Bypass code all ones, external test code all zeros.
// - Sample/preload acts exactly as bypass.
// - Instruction codes decode per the fixed code table.
// - Identification register is 32 bits, readable right after reset.
// - Configuration register is a 109-bit shift register.
// - Program/verify/erase on Idle entry; others in Update-IR. Here these and Calibrate start on the first TCK rise in Idle.
module jct_config_tap #(
    parameter ID_VALUE  = `JCT_ID_VALUE, // Arbitrary identity value
    parameter CFG_W     = `JCT_CFG_W
) (
    clk_sys,
    rst_b,
    ce,
    tck,
    tms,
    tdi,
    trst_b,
    tdo_o,
    tdo_oe,
    cfg_bits,
    lock_out,
    prog_busy,
    erase_busy,
    calib_start
);
    input  wire             clk_sys;
    input  wire             rst_b;
    input  wire             ce;
    input  wire             tck;
    input  wire             tms;
    input  wire             tdi;
    input  wire             trst_b;
    output reg              tdo_o;
    output reg              tdo_oe;
    output reg  [CFG_W-1:0] cfg_bits;
    output reg              lock_out;
    output reg              prog_busy;
    output reg              erase_busy;
    output reg              calib_start;

    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    reg  [1:0]  rst_sync_reg;
    reg  [1:0]  tck_sync_reg;
    reg  [1:0]  tms_sync_reg;
    reg  [1:0]  tdi_sync_reg;
    reg  [1:0]  trst_sync_reg;
    reg         tck_last_reg;
    wire        rst_sync_b;
    wire        tap_rst_b;
    wire        tck_s;
    wire        tck_rise;
    wire        tck_fall;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= `JCT_SYNC_RESET;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_sync_reg[1];

    // TRST acts at once; the synchronised copy only delays reset release by two clocks
    always @(posedge clk_sys or negedge trst_b) begin
        if (!trst_b) begin
            trst_sync_reg <= `JCT_SYNC_RESET;
        end else begin
            trst_sync_reg <= {trst_sync_reg[0], 1'b1};
        end
    end
    assign tap_rst_b = rst_sync_b & trst_b & trst_sync_reg[1];

    always @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tck_sync_reg <= `JCT_SYNC_RESET;
            tms_sync_reg <= 2'h3;
            tdi_sync_reg <= `JCT_SYNC_RESET;
            tck_last_reg <= 1'b0;
        end else if (ce) begin
            tck_sync_reg <= {tck_sync_reg[0], tck};
            tms_sync_reg <= {tms_sync_reg[0], tms};
            tdi_sync_reg <= {tdi_sync_reg[0], tdi};
            tck_last_reg <= tck_sync_reg[1];
        end
    end
    assign tck_s    = tck_sync_reg[1];
    assign tck_rise = tck_s & ~tck_last_reg;
    assign tck_fall = ~tck_s & tck_last_reg;

    // ****************************************
    // Controller
    // ****************************************
    wire [3:0] state;

    jct_tap_fsm u_fsm (
        .clk_sys    (clk_sys),
        .rst_sync_b (tap_rst_b),
        .ce         (ce),
        .tck_rise   (tck_rise),
        .tms        (tms_sync_reg[1]),
        .state_reg  (state)
    );

    // ****************************************
    // Instruction decode
    // ****************************************
    function [1:0] jct_sel;
        input [`JCT_IR_W-1:0] op;
        begin
            case (op)
                `JCT_OP_IDCODE:  jct_sel = 2'h1;
                `JCT_OP_SEL_CFG: jct_sel = 2'h2;
                `JCT_OP_VERIFY:  jct_sel = 2'h2;
                default:         jct_sel = 2'h0;
            endcase
        end
    endfunction

    function jct_deferred;
        input [`JCT_IR_W-1:0] op;
        begin
            jct_deferred = (op == `JCT_OP_PROGRAM) || (op == `JCT_OP_ERASE) ||
                           (op == `JCT_OP_VERIFY) || (op == `JCT_OP_CALIB);
        end
    endfunction

    // ****************************************
    // Shift paths
    // ****************************************
    reg  [`JCT_IR_W-1:0] ir_shift_reg;
    reg  [`JCT_IR_W-1:0] ir_reg;
    reg                  bypass_reg;
    reg  [`JCT_ID_W-1:0] id_shift_reg;
    reg  [CFG_W-1:0]     cfg_shift_reg;
    reg                  pend_reg;
    reg                  vfy_reg;
    wire [1:0]           sel;
    wire                 tdo_next;

    assign sel = vfy_reg ? 2'h2 : jct_sel(ir_reg);

    always @(posedge clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            ir_shift_reg  <= `JCT_OP_IDCODE;
            ir_reg        <= `JCT_OP_IDCODE;
            bypass_reg    <= 1'b0;
            id_shift_reg  <= {`JCT_ID_W{1'b0}};
            cfg_shift_reg <= {CFG_W{1'b0}};
            pend_reg      <= 1'b0;
            vfy_reg       <= 1'b0;
        end else if (ce && tck_rise) begin
            case (state)
                `JCT_ST_RESET: begin
                    ir_reg   <= `JCT_OP_IDCODE;
                    pend_reg <= 1'b0;
                    vfy_reg  <= 1'b0;
                end
                `JCT_ST_CAP_IR: begin
                    ir_shift_reg <= `JCT_OP_IDCODE;
                end
                `JCT_ST_SHIFT_IR: begin
                    ir_shift_reg <= {tdi_sync_reg[1], ir_shift_reg[`JCT_IR_W-1:1]};
                end
                `JCT_ST_UPD_IR: begin
                    ir_reg   <= ir_shift_reg;
                    pend_reg <= jct_deferred(ir_shift_reg);
                    vfy_reg  <= 1'b0;
                end
                `JCT_ST_CAP_DR: begin
                    bypass_reg   <= 1'b0;
                    id_shift_reg <= ID_VALUE;
                    if (sel == 2'h2 && !vfy_reg) begin
                        cfg_shift_reg <= lock_out ? {CFG_W{1'b0}} : cfg_bits;
                    end
                end
                `JCT_ST_SHIFT_DR: begin
                    bypass_reg    <= tdi_sync_reg[1];
                    id_shift_reg  <= {tdi_sync_reg[1], id_shift_reg[`JCT_ID_W-1:1]};
                    if (sel == 2'h2) begin
                        cfg_shift_reg <= {tdi_sync_reg[1], cfg_shift_reg[CFG_W-1:1]};
                    end
                end
                `JCT_ST_IDLE: begin
                    pend_reg <= 1'b0;
                    if (pend_reg && ir_reg == `JCT_OP_VERIFY) begin
                        cfg_shift_reg <= lock_out ? {CFG_W{1'b0}} : cfg_bits;
                        vfy_reg       <= 1'b1;
                    end
                end
                `JCT_ST_SEL_IR: begin
                    vfy_reg <= vfy_reg;
                end
                default: begin
                    pend_reg <= pend_reg;
                end
            endcase
        end
    end

    // ****************************************
    // Nonvolatile store and operations
    // ****************************************
    wire go = ce && tck_rise && state == `JCT_ST_IDLE && pend_reg;

    always @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cfg_bits    <= {CFG_W{1'b0}};
            lock_out    <= 1'b0;
            prog_busy   <= 1'b0;
            erase_busy  <= 1'b0;
            calib_start <= 1'b0;
        end else if (ce) begin
            prog_busy   <= go && ir_reg == `JCT_OP_PROGRAM;
            erase_busy  <= go && ir_reg == `JCT_OP_ERASE;
            calib_start <= go && ir_reg == `JCT_OP_CALIB;
            if (go && ir_reg == `JCT_OP_ERASE) begin
                cfg_bits <= {CFG_W{1'b0}};
                lock_out <= 1'b0;
            end else if (go && ir_reg == `JCT_OP_PROGRAM) begin
                cfg_bits <= cfg_bits | cfg_shift_reg;
                lock_out <= lock_out | cfg_shift_reg[`JCT_LOCK_POS];
            end
        end
    end

    // ****************************************
    // TDO on falling TCK
    // ****************************************
    assign tdo_next = (state == `JCT_ST_SHIFT_IR) ? ir_shift_reg[0] :
                      (sel == 2'h1) ? id_shift_reg[0] :
                      (sel == 2'h2) ? cfg_shift_reg[0] : bypass_reg;

    always @(posedge clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            tdo_o  <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (ce && tck_fall) begin
            tdo_o  <= tdo_next;
            tdo_oe <= (state == `JCT_ST_SHIFT_DR) || (state == `JCT_ST_SHIFT_IR);
        end
    end
endmodule // jct_config_tap

//--- verif/jct_config_tap_props.sv
`timescale 1ns/10ps
// ****************************************
// Port checks of the configuration TAP
// ****************************************
module jct_config_tap_props #(
    parameter CFG_W = 109
) (
    input wire             clk_sys,
    input wire             rst_b,
    input wire             ce,
    input wire             tck,
    input wire             tms,
    input wire             tdi,
    input wire             trst_b,
    input wire             tdo_o,
    input wire             tdo_oe,
    input wire [CFG_W-1:0] cfg_bits,
    input wire             lock_out,
    input wire             prog_busy,
    input wire             erase_busy,
    input wire             calib_start
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire any_op = prog_busy | erase_busy | calib_start;

    a_op_one_clk: assert property (any_op |=> !any_op)
        else $error("operation pulse longer than one clock");
    a_op_after_rise: assert property (any_op |-> $past(tck, 2))
        else $error("operation started without a test clock rise");
    a_op_single: assert property ($onehot0({prog_busy, erase_busy, calib_start}))
        else $error("two operations started together");
    a_erase_clears: assert property (erase_busy |-> ##[0:2] (cfg_bits == '0 && !lock_out))
        else $error("erase left configuration or lock set");
    a_lock_from_cfg: assert property ($rose(lock_out) |-> cfg_bits[CFG_W-1])
        else $error("lock set without its configuration bit");
    a_cfg_only_op: assert property ($changed(cfg_bits) |->
        prog_busy || $past(prog_busy) || erase_busy || $past(erase_busy))
        else $error("configuration changed outside program or erase");
    a_tdo_on_fall: assert property (disable iff (!rst_b || !trst_b)
        ($changed(tdo_o) || $changed(tdo_oe)) |-> !tck)
        else $error("serial output changed while test clock high");
    a_trst_quiet: assert property (!trst_b |=> !tdo_oe)
        else $error("serial output driven during test reset");
endmodule // jct_config_tap_props

bind jct_config_tap jct_config_tap_props #(.CFG_W(CFG_W)) i_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_b(trst_b), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .cfg_bits(cfg_bits),
    .lock_out(lock_out), .prog_busy(prog_busy), .erase_busy(erase_busy),
    .calib_start(calib_start)
);

//--- verif/jct_host_model.sv
`timescale 1ns/10ps
// ****************************************
// Serial host: test clock still between bits
// ****************************************
module jct_host_model (
    input  wire clk_sys,
    input  wire tdo_o,
    input  wire tdo_oe,
    output reg  tck,
    output reg  tms,
    output reg  tdi,
    output reg  trst_b
);
    reg  tdo_last = 1'b0;
    // Released line shows the inverse of its last level
    wire tdo_w    = tdo_oe ? tdo_o : ~tdo_last;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_b = 1'b1;
    end
    always @(posedge clk_sys) if (tdo_oe) tdo_last <= tdo_o;

    task automatic half;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic step(input bit m, input bit d, output logic q);
        tms = m;
        tdi = d;
        half;
        q = tdo_w;
        tck = 1'b1;
        half;
        tck = 1'b0;
    endtask
    task automatic walk(input logic [7:0] path, input int n);
        logic q;
        for (int i = 0; i < n; i++) step(path[i], 1'b0, q);
    endtask
    task automatic scan(input bit ir, input logic [127:0] din, input int n,
                        output logic [127:0] dout);
        logic q;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        walk(8'h01, 2);
    endtask
    task automatic pulse_trst;
        trst_b = 1'b0;
        half;
        trst_b = 1'b1;
        half;
    endtask
endmodule // jct_host_model

//--- verif/jct_config_tap_tb_top.sv
`timescale 1ns/10ps
`include "jct_defines.vh"
module jct_config_tap_tb_top;
    localparam CFG_W = `JCT_CFG_W;
    localparam logic [31:0]  ID_VAL = 32'h13572468; // Arbitrary identity value
    localparam logic [127:0] PAT    = 128'h0000_0c3a_5f00_96e1_2b7d_4488_a5a5_f00f;
    localparam logic [127:0] LOCK   = 128'h1 << `JCT_LOCK_POS;
    typedef struct {logic [4:0] op; int n; logic [127:0] exp;} jct_row_t;
    jct_row_t rows [5] = '{'{5'h00, 8, 128'h6a}, '{5'h1e, 8, 128'h6a},
        '{5'h1f, 8, 128'h6a}, '{5'h07, 8, 128'h6a}, '{5'h0d, 32, ID_VAL}};
    logic clk_sys, rst_b, ce, tck, tms, tdi, trst_b, tdo_o, tdo_oe;
    logic lock_out, prog_busy, erase_busy, calib_start;
    logic [CFG_W-1:0] cfg_bits;
    logic [127:0] q;
    int err_total = 0, total_checks = 0, n_prog = 0, n_erase = 0, n_cal = 0;

    jct_config_tap #(.ID_VALUE(ID_VAL), .CFG_W(CFG_W)) i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_b(trst_b), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .cfg_bits(cfg_bits),
        .lock_out(lock_out), .prog_busy(prog_busy), .erase_busy(erase_busy),
        .calib_start(calib_start));
    jct_host_model i_host (
        .clk_sys(clk_sys), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_b(trst_b));

    always @(posedge clk_sys) begin
        if (prog_busy === 1'b1) n_prog++;
        if (erase_busy === 1'b1) n_erase++;
        if (calib_start === 1'b1) n_cal++;
    end

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Deferred operation: load, then one clock in idle
    task automatic run_op(input logic [4:0] op);
        i_host.scan(1, op, 5, q);
        i_host.walk(8'h00, 1);
    endtask
    task automatic load_cfg(input logic [127:0] d);
        i_host.scan(1, `JCT_OP_SEL_CFG, 5, q);
        i_host.scan(0, d, CFG_W, q);
        i_host.scan(1, `JCT_OP_PROGRAM, 5, q);
    endtask
    task automatic read_cfg;
        run_op(`JCT_OP_VERIFY);
        i_host.scan(1, `JCT_OP_SEL_CFG, 5, q);
        i_host.scan(0, 128'h0, CFG_W, q);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #4000000;
        err_total++;
        give_verdict;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        repeat (5) @(negedge clk_sys);
        check("reset outputs", {tdo_o, tdo_oe, lock_out, prog_busy, erase_busy,
              calib_start, cfg_bits}, 128'h0);
        rst_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        i_host.walk(8'h00, 1);
        i_host.scan(0, 128'h0, 32, q);
        check("id after reset", q, ID_VAL);
        foreach (rows[k]) begin
            i_host.scan(1, rows[k].op, 5, q);
            check("ir capture", q, `JCT_OP_IDCODE);
            i_host.scan(0, 128'hb5, rows[k].n, q);
            check("data path", q, rows[k].exp);
        end
        check("oe in idle", tdo_oe, 1'b0);
        run_op(`JCT_OP_ERASE);
        check("erase pulse", n_erase, 1);
        load_cfg(PAT);
        check("early program", n_prog, 0);
        i_host.walk(8'h00, 1);
        check("programmed", cfg_bits, PAT);
        check("program pulse", n_prog, 1);
        read_cfg;
        check("readback", q, PAT);
        load_cfg(LOCK);
        i_host.walk(8'h00, 1);
        check("lock", {lock_out, cfg_bits}, {1'b1, PAT[CFG_W-1:0] | LOCK[CFG_W-1:0]});
        read_cfg;
        check("locked readback", q, 128'h0);
        i_host.scan(1, `JCT_OP_BYPASS, 5, q);
        i_host.walk(8'h01, 3);
        i_host.walk(8'h1f, 6);
        i_host.scan(0, 128'h0, 32, q);
        check("id after tms reset", q, ID_VAL);
        i_host.scan(1, `JCT_OP_BYPASS, 5, q);
        i_host.walk(8'h01, 5);
        i_host.pulse_trst;
        check("oe after trst", tdo_oe, 1'b0);
        i_host.walk(8'h00, 1);
        i_host.scan(0, 128'h0, 32, q);
        check("id after trst", q, ID_VAL);
        check("cfg kept", lock_out, 1'b1);
        run_op(`JCT_OP_ERASE);
        check("erased", {lock_out, cfg_bits, n_erase[1:0]}, 2'h2);
        run_op(`JCT_OP_CALIB);
        check("calibrate", {n_cal, n_prog}, {32'd1, 32'd2});
        give_verdict;
    end
endmodule // jct_config_tap_tb_top
